// *** verilog/lcdc_pkg.sv ***
// Shared constants and carrier types of the LCD controller command decoder
package lcdc_pkg;

  // ********************************
  // Opcodes
  // ********************************
  localparam logic [7:0] OP_INIT = 8'h40;
  localparam logic [7:0] OP_STANDBY = 8'h53;
  localparam logic [6:0] OP_DISPLAY_ENABLE_HI = 7'h2C;
  localparam logic [7:0] OP_SCROLL_SETUP = 8'h44;
  localparam logic [7:0] OP_GLYPH_RAM_BASE = 8'h5C;
  localparam logic [7:0] OP_CURSOR_SHAPE = 8'h5D;
  localparam logic [5:0] OP_CURSOR_DIRECTION_HI = 6'h13;
  localparam logic [7:0] OP_PIXEL_PAN = 8'h5A;
  localparam logic [7:0] OP_LAYER_OVERLAY = 8'h5B;
  localparam logic [7:0] OP_CURSOR_WRITE = 8'h46;
  localparam logic [7:0] OP_CURSOR_READ = 8'h47;
  localparam logic [7:0] OP_MEMORY_WRITE = 8'h42;
  localparam logic [7:0] OP_MEMORY_READ = 8'h43;

  // ********************************
  // Parameter counts
  // ********************************
  localparam logic [3:0] CNT_INIT = 4'h8;
  localparam logic [3:0] CNT_SCROLL = 4'hA;
  localparam logic [3:0] CNT_TWO = 4'h2;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_NONE = 4'h0;

  // ********************************
  // Parameter table layout (byte index)
  // ********************************
  localparam int TABLE_DEPTH = 24;
  localparam logic [4:0] BASE_INIT = 5'h00;
  localparam logic [4:0] BASE_SCROLL = 5'h08;
  localparam logic [4:0] BASE_GLYPH = 5'h12;
  localparam logic [4:0] BASE_SHAPE = 5'h14;
  localparam logic [4:0] BASE_PAN = 5'h16;
  localparam logic [4:0] BASE_OVERLAY = 5'h17;
  // Index of address_pitch_low inside the init list
  localparam logic [3:0] IDX_PITCH_LOW = 4'h6;
  localparam logic [3:0] IDX_PITCH_HIGH = 4'h7;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0] RST_CURSOR = 16'h0000;
  localparam logic [7:0] RST_PITCH = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_DIR = 2'h0;

  // Host side of the 8-bit bus, all inputs
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmd_data_select;
    logic [7:0] data;
  } lcdc_bus_t;

  // Display memory access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } lcdc_mem_t;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_PARAM,
    MODE_CURSOR_WRITE,
    MODE_CURSOR_READ,
    MODE_MEM_WRITE,
    MODE_MEM_READ
  } lcdc_mode_t;

endpackage

// *** verilog/lcdc_param_ram.sv ***
// Parameter byte table with two-byte write and registered read
`timescale 1ns/1ps
module lcdc_param_ram #(
  parameter int DEPTH = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Write port, lane 1 goes to waddr+1
  input wire logic [1:0] we,
  input wire logic [4:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rdata;
  logic [4:0] waddr_hi;

  always_comb begin
    waddr_hi = waddr + 5'h01;
    next_rdata = (int'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (we[0]) begin
      mem[waddr] <= wdata[7:0];
    end
    if (we[1]) begin
      mem[waddr_hi] <= wdata[15:8];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule

// *** verilog/lcdc_decoder.sv ***
// Command decoder of the graphic LCD controller behind the 8-bit host bus
// Functional notes
// - Opcodes come with select high; init 0x40 takes eight bytes, standby 0x53 none.
// - Display enable opcode is 0101100x with the flag in bit 0 and one parameter byte.
// - Opcode 0x44 is the scroll setup and takes ten parameter bytes.
// - Opcodes 0x5C (glyph RAM base) and 0x5D (cursor shape) take two bytes each.
// - Cursor direction opcode is 010011xx, the low two bits select direction, no bytes.
// - Opcodes 0x5A (pixel pan) and 0x5B (layer overlay) take one byte each.
// - Opcode 0x42 streams data bytes into display memory and 0x43 reads it back.
// - Opcodes 0x46/0x47 write/read the cursor byte by byte, low byte alone is legal.
// - Each parameter byte outside a pair updates its register as soon as it arrives.
// - A new opcode cuts the list short; written bytes stay, the rest keep old values.
// - Paired bytes of scroll and glyph base commit together; a lone low byte is dropped.
// - Pitch low and high bytes are two independent bytes, each applied on arrival.
// - The init opcode resets timing, blanks the display and leaves standby.
`timescale 1ns/1ps
module lcdc_decoder
  import lcdc_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host bus
  input wire lcdc_pkg::lcdc_bus_t bus,
  output logic [7:0] bus_rd_data,
  output logic bus_rd_oe_n,
  // Display memory
  output lcdc_pkg::lcdc_mem_t mem_req,
  input wire logic [7:0] mem_rd_data,
  // Parameter table read port for the display engine
  input wire logic [4:0] param_raddr,
  output logic [7:0] param_rdata,
  // Decoded state
  output logic timing_reset,
  output logic display_on,
  output logic standby,
  output logic [7:0] display_attr,
  output logic [1:0] cursor_dir,
  output logic [15:0] cursor,
  output logic [15:0] address_pitch
);
  import lcdc_pkg::*;

  // ********************************
  // Decode helpers
  // ********************************
  // byte counts per opcode
  function automatic logic [3:0] param_count(input logic [7:0] op);
    unique case (op)
      OP_INIT: param_count = CNT_INIT;
      OP_SCROLL_SETUP: param_count = CNT_SCROLL;
      OP_GLYPH_RAM_BASE, OP_CURSOR_SHAPE: param_count = CNT_TWO;
      OP_PIXEL_PAN, OP_LAYER_OVERLAY: param_count = CNT_ONE;
      default: param_count = (op[7:1] == OP_DISPLAY_ENABLE_HI) ? CNT_ONE : CNT_NONE;
    endcase
  endfunction

  function automatic logic [4:0] param_base(input logic [7:0] op);
    unique case (op)
      OP_SCROLL_SETUP: param_base = BASE_SCROLL;
      OP_GLYPH_RAM_BASE: param_base = BASE_GLYPH;
      OP_CURSOR_SHAPE: param_base = BASE_SHAPE;
      OP_PIXEL_PAN: param_base = BASE_PAN;
      OP_LAYER_OVERLAY: param_base = BASE_OVERLAY;
      default: param_base = BASE_INIT;
    endcase
  endfunction

  // Low half of a byte pair; the pitch bytes of init are deliberately absent
  function automatic logic pair_low(input logic [7:0] op, input logic [3:0] idx);
    if (op == OP_SCROLL_SETUP) begin
      pair_low = (idx == 4'h0) || (idx == 4'h3) || (idx == 4'h6) || (idx == 4'h8);
    end else begin
      pair_low = (op == OP_GLYPH_RAM_BASE) && (idx == 4'h0);
    end
  endfunction

  function automatic logic [15:0] cursor_step(input logic [15:0] cur, input logic [1:0] dir,
                                              input logic [15:0] pitch);
    unique case (dir)
      2'h0: cursor_step = cur + 16'h0001;
      2'h1: cursor_step = cur - 16'h0001;
      2'h2: cursor_step = cur - pitch;
      2'h3: cursor_step = cur + pitch;
    endcase
  endfunction

  // ********************************
  // Strobe edges
  // ********************************
  logic wr_prev, rd_prev;
  logic wr_take, rd_take, op_take, byte_take, data_rd;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= bus.wr_n;
      rd_prev <= bus.rd_n;
    end
  end

  always_comb begin
    wr_take = !bus.cs_n && bus.rd_n && !bus.wr_n && wr_prev;
    rd_take = !bus.cs_n && bus.wr_n && !bus.rd_n && rd_prev;
    op_take = wr_take && bus.cmd_data_select;
    byte_take = wr_take && !bus.cmd_data_select;
    data_rd = rd_take && !bus.cmd_data_select;
  end

  // ********************************
  // Decoder state
  // ********************************
  lcdc_mode_t mode, next_mode;
  logic [7:0] opcode, next_opcode;
  logic [3:0] idx, next_idx;
  logic [7:0] pend, next_pend;
  logic pend_valid, next_pend_valid;
  logic read_high, next_read_high;
  logic next_timing_reset, next_display_on, next_standby;
  logic [7:0] next_display_attr, next_bus_rd_data;
  logic [1:0] next_cursor_dir;
  logic [15:0] next_cursor, next_address_pitch;
  lcdc_mem_t next_mem_req;
  logic [1:0] ram_we;
  logic [4:0] ram_waddr;
  logic [15:0] ram_wdata;

  always_comb begin
    next_mode = mode;
    next_opcode = opcode;
    next_idx = idx;
    next_pend = pend;
    next_pend_valid = pend_valid;
    next_read_high = read_high;
    next_timing_reset = 1'b0;
    next_display_on = display_on;
    next_standby = standby;
    next_display_attr = display_attr;
    next_cursor_dir = cursor_dir;
    next_cursor = cursor;
    next_address_pitch = address_pitch;
    next_bus_rd_data = bus_rd_data;
    next_mem_req = '0;
    next_mem_req.addr = cursor;
    ram_we = 2'b00;
    ram_waddr = param_base(opcode) + {1'b0, idx};
    ram_wdata = {bus.data, bus.data};
    if (op_take) begin
      // new opcode drops what is left of the list
      next_opcode = bus.data;
      next_idx = 4'h0;
      // a lone pair byte is discarded
      next_pend_valid = 1'b0;
      next_read_high = 1'b0;
      next_mode = (param_count(bus.data) != CNT_NONE) ? MODE_PARAM : MODE_IDLE;
      unique case (bus.data)
        OP_CURSOR_WRITE: next_mode = MODE_CURSOR_WRITE;
        OP_CURSOR_READ: next_mode = MODE_CURSOR_READ;
        OP_MEMORY_WRITE: next_mode = MODE_MEM_WRITE;
        OP_MEMORY_READ: next_mode = MODE_MEM_READ;
        default: ;
      endcase
      if (bus.data == OP_INIT) begin
        next_timing_reset = 1'b1;
        next_display_on = 1'b0;
        next_standby = 1'b0;
      end
      if (bus.data == OP_STANDBY) begin
        next_standby = 1'b1;
      end
      if (bus.data[7:1] == OP_DISPLAY_ENABLE_HI) begin
        next_display_on = bus.data[0];
      end
      if (bus.data[7:2] == OP_CURSOR_DIRECTION_HI) begin
        next_cursor_dir = bus.data[1:0];
      end
    end else if (byte_take) begin
      unique case (mode)
        MODE_PARAM: begin
          if (idx < param_count(opcode)) begin
            next_idx = idx + 4'h1;
            if (pair_low(opcode, idx)) begin
              // hold the low byte until its partner arrives
              next_pend = bus.data;
              next_pend_valid = 1'b1;
            end else if (pend_valid) begin
              ram_waddr = param_base(opcode) + {1'b0, idx} - 5'h01;
              ram_wdata = {bus.data, pend};
              ram_we = 2'b11;
              next_pend_valid = 1'b0;
            end else if (opcode[7:1] != OP_DISPLAY_ENABLE_HI) begin
              // single byte applied on arrival; the display flag byte has no table slot
              ram_we = 2'b01;
            end
            if (opcode[7:1] == OP_DISPLAY_ENABLE_HI) begin
              next_display_attr = bus.data;
            end
            // pitch bytes applied one at a time
            if (opcode == OP_INIT && idx == IDX_PITCH_LOW) begin
              next_address_pitch[7:0] = bus.data;
            end
            if (opcode == OP_INIT && idx == IDX_PITCH_HIGH) begin
              next_address_pitch[15:8] = bus.data;
            end
          end
        end
        MODE_CURSOR_WRITE: begin
          // each cursor byte on its own
          if (idx == 4'h0) begin
            next_cursor[7:0] = bus.data;
          end else if (idx == 4'h1) begin
            next_cursor[15:8] = bus.data;
          end
          if (idx < CNT_TWO) begin
            next_idx = idx + 4'h1;
          end
        end
        MODE_MEM_WRITE: begin
          next_mem_req.valid = 1'b1;
          next_mem_req.write = 1'b1;
          next_mem_req.data = bus.data;
          next_cursor = cursor_step(cursor, cursor_dir, address_pitch);
        end
        default: ;
      endcase
    end else if (data_rd) begin
      unique case (mode)
        MODE_CURSOR_READ: begin
          next_bus_rd_data = read_high ? cursor[15:8] : cursor[7:0];
          next_read_high = 1'b1;
        end
        MODE_MEM_READ: begin
          // read at the cursor, then advance
          next_bus_rd_data = mem_rd_data;
          next_mem_req.valid = 1'b1;
          next_cursor = cursor_step(cursor, cursor_dir, address_pitch);
        end
        default: next_bus_rd_data = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_IDLE;
      opcode <= RST_BYTE;
      idx <= 4'h0;
      pend <= RST_BYTE;
      pend_valid <= 1'b0;
      read_high <= 1'b0;
      timing_reset <= 1'b0;
      display_on <= 1'b0;
      standby <= 1'b0;
      display_attr <= RST_BYTE;
      cursor_dir <= RST_DIR;
      cursor <= RST_CURSOR;
      address_pitch <= {RST_PITCH, RST_PITCH};
      bus_rd_data <= RST_BYTE;
      mem_req <= '0;
    end else begin
      mode <= next_mode;
      opcode <= next_opcode;
      idx <= next_idx;
      pend <= next_pend;
      pend_valid <= next_pend_valid;
      read_high <= next_read_high;
      timing_reset <= next_timing_reset;
      display_on <= next_display_on;
      standby <= next_standby;
      display_attr <= next_display_attr;
      cursor_dir <= next_cursor_dir;
      cursor <= next_cursor;
      address_pitch <= next_address_pitch;
      bus_rd_data <= next_bus_rd_data;
      mem_req <= next_mem_req;
    end
  end

  // Drives while a read strobe is held past its first cycle, for either select; status reads leave bus_rd_data unchanged
  assign bus_rd_oe_n = !(!bus.cs_n && !bus.rd_n && !rd_prev);

  lcdc_param_ram #(
    .DEPTH(DEPTH)
  ) u_table (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(param_raddr),
    .rdata(param_rdata)
  );

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_op(logic [7:0] code);
    op_take && bus.data == code;
  endsequence

  // Pulse in the cycle after the opcode, gone one cycle later
  sequence s_init_effect;
    timing_reset && !display_on && !standby ##1 !timing_reset;
  endsequence

  // A data read in cursor-read mode, before or after the low byte went out
  sequence s_cursor_rd(logic hi);
    data_rd && mode == MODE_CURSOR_READ && read_high == hi;
  endsequence

  a_init_blanks_wakes: assert property (s_op(OP_INIT) |=> s_init_effect)
    else $error("init opcode effects wrong");
  a_standby_entry: assert property (s_op(OP_STANDBY) |=> standby && mode == MODE_IDLE)
    else $error("standby opcode not applied");
  a_display_flag: assert property (op_take && bus.data[7:1] == OP_DISPLAY_ENABLE_HI |=>
    display_on == $past(bus.data[0]) && mode == MODE_PARAM) else $error("display flag");
  a_flag_attr: assert property (byte_take && mode == MODE_PARAM && idx == 4'h0
    && opcode[7:1] == OP_DISPLAY_ENABLE_HI |-> ram_we == 2'b00
    ##1 display_attr == $past(bus.data)) else $error("display attribute");
  a_dir_field: assert property (op_take && bus.data[7:2] == OP_CURSOR_DIRECTION_HI |=>
    cursor_dir == $past(bus.data[1:0]) && mode == MODE_IDLE) else $error("direction");
  a_pair_held: assert property (byte_take && mode == MODE_PARAM && pair_low(opcode, idx)
    && idx < param_count(opcode) |-> ram_we == 2'b00) else $error("pair low written");
  a_single_prompt: assert property (byte_take && mode == MODE_PARAM && !pend_valid
    && !pair_low(opcode, idx) && idx < param_count(opcode)
    && opcode[7:1] != OP_DISPLAY_ENABLE_HI |-> ram_we == 2'b01)
    else $error("single byte not applied");
  a_new_op_cuts: assert property (op_take |=> idx == 4'h0 && !pend_valid)
    else $error("list not cut by opcode");
  a_pitch_low: assert property (byte_take && mode == MODE_PARAM && opcode == OP_INIT
    && idx == IDX_PITCH_LOW |=> address_pitch[7:0] == $past(bus.data)
    && address_pitch[15:8] == $past(address_pitch[15:8])) else $error("pitch low");
  a_cursor_low: assert property (byte_take && mode == MODE_CURSOR_WRITE && idx == 4'h0 |=>
    cursor[7:0] == $past(bus.data) && cursor[15:8] == $past(cursor[15:8]))
    else $error("cursor low byte");
  a_cursor_read_order: assert property (s_cursor_rd(1'b0) |=> read_high
    && bus_rd_data == $past(cursor[7:0])) else $error("cursor read order");
  a_cursor_read_high: assert property (s_cursor_rd(1'b1) |=> read_high
    && bus_rd_data == $past(cursor[15:8])) else $error("cursor high byte");
  a_mem_stream: assert property (byte_take && mode == MODE_MEM_WRITE |=> mem_req.valid
    && mem_req.write && mem_req.data == $past(bus.data)) else $error("memory write");
endmodule

// *** test/lcdc_host_model.sv ***
// Host microprocessor model driving the 8-bit command/data bus
`timescale 1ns/1ps
module lcdc_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus towards the decoder
  output lcdc_pkg::lcdc_bus_t bus,
  input wire logic [7:0] bus_rd_data,
  input wire logic bus_rd_oe_n,
  // Pulses captured in the answer cycle
  input wire logic timing_reset,
  input wire lcdc_pkg::lcdc_mem_t mem_req
);
  import lcdc_pkg::*;

  // Extra idle cycles after each strobe, raised for a slow host
  int gap = 0;
  logic seen_treset;
  lcdc_mem_t seen_mem;
  logic [7:0] rd_val;
  logic rd_oe_n;

  initial begin
    bus = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
  end

  // select marks opcode or byte, any order
  task automatic wr(input logic cd, input logic [7:0] val);
    @(negedge clk_sys);
    bus = '{1'b0, 1'b0, 1'b1, cd, val};
    @(negedge clk_sys);
    seen_treset = timing_reset;
    seen_mem = mem_req;
    // Released data lines flip so a stale byte is never reused
    bus = '{1'b1, 1'b1, 1'b1, cd, ~val};
    repeat (1 + gap) @(negedge clk_sys);
  endtask

  // cursor bytes read one per strobe
  task automatic rd(input logic cd);
    @(negedge clk_sys);
    bus = '{1'b0, 1'b1, 1'b0, cd, 8'h5A};
    @(negedge clk_sys);
    // Memory request pulse stands only in the cycle after the read edge
    seen_mem = mem_req;
    @(negedge clk_sys);
    rd_val = bus_rd_data;
    rd_oe_n = bus_rd_oe_n;
    bus = '{1'b1, 1'b1, 1'b1, cd, 8'hA5};
    repeat (1 + gap) @(negedge clk_sys);
  endtask
endmodule

// *** test/lcdc_decoder_tb_top.sv ***
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module lcdc_decoder_tb_top;
  import lcdc_pkg::*;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  lcdc_bus_t bus;
  logic [7:0] bus_rd_data;
  logic bus_rd_oe_n;
  lcdc_mem_t mem_req;
  logic [7:0] mem_rd_data = 8'h00;
  logic [4:0] param_raddr = 5'h00;
  logic [7:0] param_rdata;
  logic timing_reset;
  logic display_on;
  logic standby;
  logic [7:0] display_attr;
  logic [1:0] cursor_dir;
  logic [15:0] cursor;
  logic [15:0] address_pitch;
  logic [7:0] v;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  lcdc_decoder dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .bus_rd_data(bus_rd_data),
    .bus_rd_oe_n(bus_rd_oe_n), .mem_req(mem_req), .mem_rd_data(mem_rd_data),
    .param_raddr(param_raddr), .param_rdata(param_rdata), .timing_reset(timing_reset),
    .display_on(display_on), .standby(standby), .display_attr(display_attr),
    .cursor_dir(cursor_dir), .cursor(cursor), .address_pitch(address_pitch)
  );

  lcdc_host_model host (
    .clk_sys(clk_sys), .bus(bus), .bus_rd_data(bus_rd_data), .bus_rd_oe_n(bus_rd_oe_n),
    .timing_reset(timing_reset), .mem_req(mem_req)
  );

  // ********************************
  // Helpers
  // ********************************
  task automatic op(input logic [7:0] b);
    host.wr(1'b1, b);
  endtask

  task automatic prm(input logic [7:0] b);
    host.wr(1'b0, b);
  endtask

  // Table read port answers one cycle after the address
  task automatic tab(input logic [4:0] a);
    @(negedge clk_sys);
    param_raddr = a;
    repeat (2) @(negedge clk_sys);
    v = param_rdata;
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_init;
    int i;
    op(OP_STANDBY);
    `CHK(standby, 1'b1)
    op(OP_INIT);
    `CHK(host.seen_treset, 1'b1)
    `CHK({timing_reset, standby, display_on}, 3'b000)
    for (i = 0; i < 8; i++) begin
      prm(8'h10 + 8'(i));
      tab(5'(i));
      `CHK(v, 8'h10 + 8'(i))
      if (i == 6) `CHK(address_pitch, 16'h0016)
    end
    `CHK(address_pitch, 16'h1716)
    // Init cut after its first byte
    op(OP_INIT);
    prm(8'h20);
    op(OP_LAYER_OVERLAY);
    tab(5'h00);
    `CHK(v, 8'h20)
    tab(5'h01);
    `CHK(v, 8'h11)
  endtask

  task automatic t_disp;
    int i;
    for (i = 1; i >= 0; i--) begin
      op({OP_DISPLAY_ENABLE_HI, 1'(i)});
      prm(8'h30 + 8'(i));
      `CHK({display_on, display_attr}, {1'(i), 8'h30 + 8'(i)})
    end
    // The flag byte must not land in the init slot
    tab(5'h00);
    `CHK(v, 8'h20)
  endtask

  task automatic t_scroll;
    int i;
    // Table memory has no reset; clear the glyph slots that follow the scroll list
    op(OP_GLYPH_RAM_BASE);
    prm(8'h00);
    prm(8'h00);
    op(OP_SCROLL_SETUP);
    for (i = 0; i < 10; i++) prm(8'h40 + 8'(i));
    prm(8'h4A);
    for (i = 0; i < 11; i++) begin
      tab(5'h08 + 5'(i));
      `CHK(v, (i < 10) ? 8'h40 + 8'(i) : 8'h00)
    end
    op(OP_SCROLL_SETUP);
    prm(8'h50);
    tab(5'h08);
    `CHK(v, 8'h40)
    prm(8'h51);
    tab(5'h09);
    `CHK(v, 8'h51)
    prm(8'h52);
    tab(5'h0A);
    `CHK(v, 8'h52)
    prm(8'h53);
    op(OP_LAYER_OVERLAY);
    tab(5'h0B);
    `CHK(v, 8'h43)
    tab(5'h0C);
    `CHK(v, 8'h44)
  endtask

  task automatic t_short;
    int i;
    op(OP_GLYPH_RAM_BASE);
    prm(8'h60);
    prm(8'h61);
    op(OP_CURSOR_SHAPE);
    prm(8'h62);
    prm(8'h63);
    op(OP_PIXEL_PAN);
    prm(8'h64);
    prm(8'h65);
    op(OP_LAYER_OVERLAY);
    prm(8'h66);
    op(OP_GLYPH_RAM_BASE);
    prm(8'h70);
    op(OP_CURSOR_READ);
    for (i = 0; i < 6; i++) begin
      tab(5'h12 + 5'(i));
      `CHK(v, (i < 5) ? 8'h60 + 8'(i) : 8'h66)
    end
  endtask

  task automatic t_dir;
    int i;
    for (i = 0; i < 4; i++) begin
      op({OP_CURSOR_DIRECTION_HI, 2'(i)});
      `CHK(cursor_dir, 2'(i))
    end
  endtask

  task automatic t_cursor;
    op(OP_CURSOR_WRITE);
    prm(8'h34);
    prm(8'h12);
    `CHK(cursor, 16'h1234)
    op(OP_CURSOR_WRITE);
    prm(8'h78);
    `CHK(cursor, 16'h1278)
    op(OP_CURSOR_READ);
    host.gap = 2;
    host.rd(1'b0);
    `CHK({host.rd_oe_n, host.rd_val}, 9'h078)
    host.rd(1'b0);
    host.gap = 0;
    `CHK({host.rd_oe_n, host.rd_val}, 9'h012)
    `CHK(bus_rd_oe_n, 1'b1)
  endtask

  task automatic t_mem;
    op({OP_CURSOR_DIRECTION_HI, 2'b00});
    op(OP_MEMORY_WRITE);
    prm(8'hA1);
    `CHK(host.seen_mem, {1'b1, 1'b1, 16'h1278, 8'hA1})
    `CHK({mem_req.valid, cursor}, {1'b0, 16'h1279})
    prm(8'hA2);
    `CHK(host.seen_mem, {1'b1, 1'b1, 16'h1279, 8'hA2})
    op({OP_CURSOR_DIRECTION_HI, 2'b11});
    op(OP_MEMORY_READ);
    mem_rd_data = 8'hC3;
    host.rd(1'b0);
    `CHK({host.rd_val, cursor}, {8'hC3, 16'h2990})
    `CHK(host.seen_mem, {1'b1, 1'b0, 16'h127A, 8'h00})
    op({OP_CURSOR_DIRECTION_HI, 2'b10});
    op(OP_MEMORY_READ);
    host.rd(1'b0);
    `CHK(cursor, 16'h127A)
    op({OP_CURSOR_DIRECTION_HI, 2'b01});
    op(OP_MEMORY_READ);
    host.rd(1'b0);
    `CHK({host.rd_val, cursor}, {8'hC3, 16'h1279})
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    t_init();
    t_disp();
    t_scroll();
    t_short();
    t_dir();
    t_cursor();
    t_mem();
    test_done();
  end

  // Cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
endmodule
